/* File: bfe_pkg.sv */
package bfe_pkg;
  typedef enum logic {FILL_ZERO, FILL_SIGN} fill_t;
  typedef logic [2:0] reg_idx_t;
  typedef logic [4:0] bit_pos_t;
  typedef struct packed {
    logic [7:0][31:0] data;
    logic [31:0] flags;
    logic [31:0] result;
    logic [31:0] rdata;
  } core_state_t;
endpackage

/* File: bfe_regs.svh */
`ifndef BFE_REGS_SVH
`define BFE_REGS_SVH

`define ADDR_W 8
`define REG_DATA0 8'h00
`define REG_DATA_LAST 8'h1c
`define REG_CMD 8'h20
`define REG_FLAGS 8'h24
`define REG_RESULT 8'h28

`define CMD_DST_LSB 0
`define CMD_SRC_LSB 4
`define CMD_PAT_LSB 8
`define CMD_SIGN_BIT 12
`define CMD_PAR_BIT 15
`define CMD_OPC_LSB 24
`define CMD_OPC_VAL 8'hc6

`define PAT_POS_LSB 8
`define PAT_LEN_LSB 0
`define FIELD_W 5
`define WORD_W 32

`define FLG_ZERO 0
`define FLG_NEG 1
`define FLG_CARRY 2
`define FLG_OVF 3
`define FLG_ILL 8
`define FLG_PAR 9
`define FLG_SW_MASK 32'h0000_00ff
`define FLG_RST 32'h0000_0000
`define WORD_RST 32'h0000_0000

`endif

/* File: bit_field_extract_unit.sv */
// Our own choices: the register addresses and the plain strobed port.
`timescale 1ns/1ns
`default_nettype none
`include "bfe_regs.svh"
module bit_field_extract_unit
  import bfe_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // Register port
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [31:0] rdata,
  // Flag outputs
  output logic zero_flag,
  output logic negative_flag,
  output logic carry_flag,
  output logic overflow_flag
);
  core_state_t cur_r;
  core_state_t cur_nxt;

  reg_idx_t cmd_dst;
  reg_idx_t cmd_src;
  reg_idx_t cmd_pat;
  fill_t cmd_fill;
  logic cmd_par;
  logic cmd_hit;
  logic cmd_ok;
  logic [31:0] op_scene;
  logic [15:0] op_pattern;
  logic [31:0] ext_result;
  logic [31:0] ext_flags;

  // A data register is any aligned word in the low eight slots.
  function automatic logic data_hit(input logic [7:0] a);
    data_hit = (a <= `REG_DATA_LAST) && (a[1:0] == 2'h0);
  endfunction

  function automatic reg_idx_t data_index(input logic [7:0] a);
    data_index = a[4:2];
  endfunction

  always_comb
  begin
    cmd_dst = wdata[`CMD_DST_LSB +: 3];
    cmd_src = wdata[`CMD_SRC_LSB +: 3];
    cmd_pat = wdata[`CMD_PAT_LSB +: 3];
    cmd_fill = wdata[`CMD_SIGN_BIT] ? FILL_SIGN : FILL_ZERO;
    cmd_par = wdata[`CMD_PAR_BIT];
    cmd_hit = wr_en && (addr == `REG_CMD);
    // Any other opcode is not the long extract form and is refused.
    cmd_ok = cmd_hit && (wdata[`CMD_OPC_LSB +: 8] == `CMD_OPC_VAL);
  end

  // Operands are read from the current state, before any write-back.
  assign op_scene = cur_r.data[cmd_src];
  assign op_pattern = cur_r.data[cmd_pat][15:0];

  field_extract u_extract (
    .scene(op_scene),
    .pattern(op_pattern),
    .fill(cmd_fill),
    .field(ext_result)
  );

  flag_calc u_flags (
    .result(ext_result),
    .old_flags(cur_r.flags),
    .par_issue(cmd_par),
    .new_flags(ext_flags)
  );

  always_comb
  begin
    cur_nxt = cur_r;
    cur_nxt.rdata = `WORD_RST;
    if (wr_en)
    begin
      if (data_hit(addr))
      begin
        cur_nxt.data[data_index(addr)] = wdata;
      end
      else if (cmd_ok)
      begin
        // Only the destination slot is written back.
        cur_nxt.data[cmd_dst] = ext_result;
        cur_nxt.result = ext_result;
        cur_nxt.flags = ext_flags;
      end
      else if (cmd_hit)
      begin
        cur_nxt.flags[`FLG_ILL] = 1'b1;
      end
      else if (addr == `REG_FLAGS)
      begin
        cur_nxt.flags = (cur_r.flags & ~`FLG_SW_MASK)
          | (wdata & `FLG_SW_MASK);
        if (wdata[`FLG_ILL])
        begin
          cur_nxt.flags[`FLG_ILL] = 1'b0;
        end
      end
    end
    if (rd_en)
    begin
      if (data_hit(addr))
        cur_nxt.rdata = cur_r.data[data_index(addr)];
      else if (addr == `REG_FLAGS)
        cur_nxt.rdata = cur_r.flags;
      else if (addr == `REG_RESULT)
        cur_nxt.rdata = cur_r.result;
      else
        cur_nxt.rdata = `WORD_RST;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      cur_r.data <= '0;
      cur_r.flags <= `FLG_RST;
      cur_r.result <= `WORD_RST;
      cur_r.rdata <= `WORD_RST;
    end
    else
    begin
      cur_r <= cur_nxt;
    end
  end

  assign rdata = cur_r.rdata;
  assign zero_flag = cur_r.flags[`FLG_ZERO];
  assign negative_flag = cur_r.flags[`FLG_NEG];
  assign carry_flag = cur_r.flags[`FLG_CARRY];
  assign overflow_flag = cur_r.flags[`FLG_OVF];

  // Checking helpers, computed apart from the extract path.
  logic [4:0] chk_pos;
  logic [4:0] chk_len;
  logic [5:0] chk_end;
  logic [31:0] chk_shift;
  logic [31:0] chk_mask;
  logic chk_top;
  logic [31:0] chk_ref;

  // Bit by bit reference, so a slip in the shift and mask path cannot
  // hide behind a copy of the same expression.
  function automatic logic [31:0] ref_field(input logic [31:0] s,
    input bit_pos_t p, input bit_pos_t l, input fill_t f);
    logic [31:0] r;
    logic top;
    r = `WORD_RST;
    top = 1'b0;
    for (int i = 0; i < `WORD_W; i++)
    begin
      if (i < int'(l))
      begin
        if (i + int'(p) < `WORD_W)
          r[i] = s[i + int'(p)];
        top = r[i];
      end
      else if (f == FILL_SIGN)
      begin
        r[i] = top;
      end
    end
    ref_field = r;
  endfunction

  always_comb
  begin
    chk_pos = op_pattern[12:8];
    chk_len = op_pattern[4:0];
    chk_end = {1'b0, chk_pos} + {1'b0, chk_len};
    chk_shift = op_scene >> chk_pos;
    chk_mask = 32'((64'h1 << chk_len) - 64'h1);
    chk_top = (chk_len != 5'h00) ? chk_shift[chk_len - 5'h01] : 1'b0;
    chk_ref = ref_field(op_scene, chk_pos, chk_len, cmd_fill);
  end

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (reset);

  extract_low_a: assert property (
    cmd_ok && cmd_fill == FILL_ZERO
    |=> cur_r.result == $past(chk_shift & chk_mask))
    else $error("zero-fill extract result wrong");

  field_start_a: assert property (
    cmd_ok && chk_len != 5'h00
    |=> cur_r.result[0] == $past(op_scene[chk_pos]))
    else $error("result bit 0 is not source bit p");

  sign_fill_a: assert property (
    cmd_ok && cmd_fill == FILL_SIGN && chk_top
    |=> cur_r.result == ($past(chk_shift & chk_mask) | ~$past(chk_mask)))
    else $error("sign fill did not set upper bits");

  top_pos_a: assert property (
    cmd_ok && chk_pos == 5'h1f && chk_len == 5'h01
    |=> cur_r.result == {31'h0, $past(op_scene[31])} ||
      $past(cmd_fill) == FILL_SIGN)
    else $error("position 31 not taken");

  long_len_a: assert property (
    cmd_ok && chk_pos == 5'h00 && chk_len == 5'h1f &&
      cmd_fill == FILL_ZERO
    |=> cur_r.result == {1'b0, $past(op_scene[30:0])})
    else $error("length 31 field wrong");

  past_top_a: assert property (
    cmd_ok && chk_end > 6'h20
    |=> (cur_r.result >> (6'h20 - {1'b0, $past(chk_pos)})) == 32'h0)
    else $error("bits beyond word were not zero");

  src_keep_a: assert property (
    cmd_ok && cmd_dst != cmd_src
    |=> cur_r.data[$past(cmd_src)] == $past(op_scene))
    else $error("source register changed");

  alias_dst_a: assert property (
    cmd_ok && cmd_dst == cmd_src
    |=> cur_r.data[$past(cmd_dst)] == $past(ext_result) ##1
      cur_r.data[$past(cmd_dst, 2)] == $past(ext_result, 2) ||
      $past(wr_en))
    else $error("aliased destination wrong");

  zero_flag_a: assert property (
    cmd_ok |=> zero_flag == (cur_r.result == 32'h0))
    else $error("zero flag mismatch");

  neg_flag_a: assert property (
    cmd_ok |=> negative_flag == cur_r.result[31])
    else $error("negative flag mismatch");

  cv_clear_a: assert property (
    cmd_ok |=> !carry_flag && !overflow_flag &&
      cur_r.flags[7:4] == $past(cur_r.flags[7:4]))
    else $error("carry or overflow not cleared");

  bad_opcode_a: assert property (
    cmd_hit && !cmd_ok
    |=> $stable(cur_r.result) && $stable(cur_r.data) &&
      cur_r.flags[`FLG_ILL])
    else $error("refused command had an effect");

  par_mark_a: assert property (
    cmd_ok |=> cur_r.flags[`FLG_PAR] == $past(cmd_par))
    else $error("parallel mark not recorded");

  pattern_field_a: assert property (
    cmd_ok && chk_len == 5'h01 && cmd_fill == FILL_ZERO
    |=> cur_r.result == {31'h0, $past(op_scene[chk_pos])})
    else $error("pattern fields misread");

  len_zero_a: assert property (
    cmd_ok && chk_len == 5'h00
    |=> cur_r.result == 32'h0 && zero_flag)
    else $error("zero length not all zero");

  read_timing_a: assert property (
    rd_en && addr == `REG_RESULT
    |=> rdata == $past(cur_r.result))
    else $error("read data not in next cycle");

  rdata_idle_a: assert property (
    !rd_en |=> rdata == 32'h0)
    else $error("read data not cleared outside the read cycle");

  data_write_a: assert property (
    wr_en && data_hit(addr)
    |=> cur_r.data[$past(data_index(addr))] == $past(wdata))
    else $error("data register write lost");

  data_read_a: assert property (
    rd_en && data_hit(addr)
    |=> rdata == $past(cur_r.data[data_index(addr)]))
    else $error("data register read wrong");

  flags_read_a: assert property (
    rd_en && addr == `REG_FLAGS |=> rdata == $past(cur_r.flags))
    else $error("flag register read wrong");

  result_ro_a: assert property (
    wr_en && addr == `REG_RESULT |=> $stable(cur_r.result))
    else $error("result register took a write");

  flag_write_a: assert property (
    wr_en && addr == `REG_FLAGS
    |=> (cur_r.flags & `FLG_SW_MASK) == ($past(wdata) & `FLG_SW_MASK) &&
      $stable(cur_r.flags[`FLG_PAR]))
    else $error("flag register write wrong");

  refused_clear_a: assert property (
    wr_en && addr == `REG_FLAGS && wdata[`FLG_ILL]
    |=> !cur_r.flags[`FLG_ILL])
    else $error("refused mark not cleared");

  refused_sticky_a: assert property (
    cur_r.flags[`FLG_ILL] &&
      !(wr_en && addr == `REG_FLAGS && wdata[`FLG_ILL])
    |=> cur_r.flags[`FLG_ILL])
    else $error("refused mark dropped");

  dest_write_a: assert property (
    cmd_ok |=> cur_r.data[$past(cmd_dst)] == cur_r.result)
    else $error("destination not written with result");

  ref_model_a: assert property (
    cmd_ok |=> cur_r.result == $past(chk_ref))
    else $error("result differs from bit reference");

  sign_neg_c: cover property (
    cmd_ok && cmd_fill == FILL_SIGN && chk_top ##1 negative_flag);

  overrun_c: cover property (cmd_ok && chk_end > 6'h20);

  alias_c: cover property (cmd_ok && cmd_dst == cmd_pat);

  refused_c: cover property (cmd_hit && !cmd_ok);

  len_zero_c: cover property (cmd_ok && chk_len == 5'h00);
endmodule
`default_nettype wire

/* File: bit_field_extract_unit_bench.sv */
`timescale 1ns/1ns
`default_nettype none
`include "bfe_regs.svh"
`define CHECK(nm, e, g) \
  begin \
    comparisons++; \
    if ((g) !== (e)) \
    begin \
      err_count++; \
      $display("[FAIL] %s expected %h seen %h", nm, e, g); \
    end \
  end
module bit_field_extract_unit_bench;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] addr;
  logic [31:0] wdata, rdata;
  logic wr_en, rd_en, zero_flag, negative_flag, carry_flag, overflow_flag;
  int err_count = 0;
  int comparisons = 0;
  int cycles = 0;
  always #5 ref_clk = ~ref_clk;
  bit_field_extract_unit bit_field_extract_unit_inst (.ref_clk(ref_clk),
    .reset(reset), .addr(addr), .wdata(wdata), .wr_en(wr_en),
    .rd_en(rd_en), .rdata(rdata), .zero_flag(zero_flag),
    .negative_flag(negative_flag), .carry_flag(carry_flag),
    .overflow_flag(overflow_flag));
  issue_model issue_model_inst (.ref_clk(ref_clk), .addr(addr),
    .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata));
  function automatic logic [31:0] exp_field(logic [31:0] s,
    logic [4:0] p, logic [4:0] l, logic sg);
    logic [31:0] m;
    logic [31:0] f;
    m = (32'h1 << l) - 32'h1;
    f = (s >> p) & m;
    if (sg && l != 5'd0 && f[l - 5'd1])
      f = f | ~m;
    return f;
  endfunction
  // Pattern upper half carries junk, which the unit must ignore.
  task automatic run_case(logic [31:0] s, logic [4:0] p, logic [4:0] l,
    logic sg, logic par, logic [2:0] dst);
    logic [31:0] e, v;
    e = exp_field(s, p, l, sg);
    issue_model_inst.wr(8'h04, s);
    issue_model_inst.wr(8'h08, {16'h5a5a, 3'b111, p, 3'b111, l});
    issue_model_inst.wr(`REG_FLAGS, 32'h0000_00fc);
    #1;
    `CHECK("carry_ovf_set", 2'b11, {overflow_flag, carry_flag})
    issue_model_inst.issue(`CMD_OPC_VAL, dst, 3'd1, 3'd2, sg, par);
    #1;
    `CHECK("zero_flag", e == 32'h0, zero_flag)
    `CHECK("negative_flag", e[31], negative_flag)
    `CHECK("carry_ovf", 2'b00, {overflow_flag, carry_flag})
    issue_model_inst.rd(`REG_RESULT, v);
    `CHECK("result", e, v)
    issue_model_inst.rd({3'b000, dst, 2'b00}, v);
    `CHECK("dest", e, v)
    if (dst != 3'd1)
    begin
      issue_model_inst.rd(8'h04, v);
      `CHECK("source", s, v)
    end
    issue_model_inst.rd(`REG_FLAGS, v);
    `CHECK("flags", {22'h0, par, 5'h0f, 2'b00, e[31], e == 32'h0}, v)
  endtask
  task automatic test_reset();
    logic [31:0] v;
    #1;
    `CHECK("flags_out", 4'h0, {overflow_flag, carry_flag, negative_flag,
      zero_flag})
    issue_model_inst.rd(8'h00, v);
    `CHECK("data0", 32'h0, v)
    issue_model_inst.wr(8'h40, 32'hdead_beef);
    issue_model_inst.rd(8'h40, v);
    `CHECK("unmapped", 32'h0, v)
    $display("test reset done");
  endtask
  task automatic test_examples();
    logic [31:0] v;
    run_case(32'ha5a5_c3aa, 5'd7, 5'd4, 1'b0, 1'b0, 3'd3);
    issue_model_inst.rd(`REG_RESULT, v);
    `CHECK("example_a", 32'h0000_0007, v)
    run_case(32'ha5a5_c3aa, 5'd13, 5'd9, 1'b0, 1'b0, 3'd3);
    issue_model_inst.rd(`REG_RESULT, v);
    `CHECK("example_b", 32'h0000_012e, v)
    run_case(32'ha5a5_c3aa, 5'd13, 5'd9, 1'b1, 1'b1, 3'd3);
    issue_model_inst.rd(`REG_RESULT, v);
    `CHECK("example_c", 32'hffff_ff2e, v)
    $display("test examples done");
  endtask
  // Edge positions and lengths where off-by-one slips show up.
  task automatic test_bounds();
    run_case(32'hffff_ffff, 5'd28, 5'd8, 1'b1, 1'b0, 3'd4);
    run_case(32'hffff_ffff, 5'd31, 5'd31, 1'b0, 1'b0, 3'd4);
    run_case(32'hffff_ffff, 5'd0, 5'd31, 1'b1, 1'b0, 3'd4);
    run_case(32'hffff_ffff, 5'd5, 5'd0, 1'b1, 1'b0, 3'd4);
    $display("test bounds done");
  endtask
  task automatic test_alias();
    run_case(32'h8123_4567, 5'd4, 5'd12, 1'b1, 1'b0, 3'd1);
    run_case(32'h8123_4567, 5'd16, 5'd16, 1'b1, 1'b0, 3'd2);
    $display("test alias done");
  endtask
  task automatic test_refused();
    logic [31:0] v0, v;
    issue_model_inst.rd(`REG_RESULT, v0);
    issue_model_inst.issue(8'h00, 3'd5, 3'd1, 3'd2, 1'b0, 1'b0);
    issue_model_inst.rd(`REG_RESULT, v);
    `CHECK("refused_result", v0, v)
    issue_model_inst.rd(`REG_FLAGS, v);
    `CHECK("refused_flag", 1'b1, v[`FLG_ILL])
    issue_model_inst.wr(`REG_FLAGS, 32'h0000_0100);
    issue_model_inst.rd(`REG_FLAGS, v);
    `CHECK("refused_clear", 1'b0, v[`FLG_ILL])
    $display("test refused done");
  endtask
  // A reset in mid-run must clear registers, flags and result alike.
  task automatic test_midreset();
    logic [31:0] v;
    issue_model_inst.wr(`REG_FLAGS, 32'h0000_000f);
    @(posedge ref_clk);
    reset <= 1'b1;
    repeat (2) @(posedge ref_clk);
    reset <= 1'b0;
    #1;
    `CHECK("rst_flags", 4'h0, {overflow_flag, carry_flag, negative_flag,
      zero_flag})
    issue_model_inst.rd(`REG_RESULT, v);
    `CHECK("rst_result", 32'h0, v)
    issue_model_inst.rd(8'h04, v);
    `CHECK("rst_data", 32'h0, v)
    issue_model_inst.rd(`REG_FLAGS, v);
    `CHECK("rst_flag_reg", 32'h0, v)
    $display("test midreset done");
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      err_count++;
      summarize();
    end
  end
  initial
  begin
    repeat (4) @(posedge ref_clk);
    reset <= 1'b0;
    test_reset();
    test_examples();
    test_bounds();
    test_alias();
    test_refused();
    test_midreset();
    summarize();
  end
endmodule
`default_nettype wire

/* File: field_extract.sv */
`timescale 1ns/1ns
`default_nettype none
`include "bfe_regs.svh"
module field_extract
  import bfe_pkg::*;
(
  // Operands
  input wire logic [31:0] scene,
  input wire logic [15:0] pattern,
  input wire fill_t fill,
  // Result
  output logic [31:0] field
);
  logic [4:0] pos;
  logic [4:0] len;
  logic [31:0] shifted;
  logic [31:0] mask;
  logic top;

  always_comb
  begin
    pos = pattern[`PAT_POS_LSB +: `FIELD_W];
    len = pattern[`PAT_LEN_LSB +: `FIELD_W];
    // Zeros shift in from above, so bits past the word read as zero.
    shifted = scene >> pos;
    mask = 32'((33'h1 << len) - 33'h1);
    top = (len != 5'h00) ? shifted[len - 5'h01] : 1'b0;
    if (fill == FILL_SIGN && top)
      field = (shifted & mask) | ~mask;
    else
      field = shifted & mask;
  end
endmodule
`default_nettype wire

/* File: flag_calc.sv */
`timescale 1ns/1ns
`default_nettype none
`include "bfe_regs.svh"
module flag_calc
(
  // Inputs
  input wire logic [31:0] result,
  input wire logic [31:0] old_flags,
  input wire logic par_issue,
  // Updated flags
  output logic [31:0] new_flags
);
  always_comb
  begin
    new_flags = old_flags;
    new_flags[`FLG_ZERO] = (result == `WORD_RST);
    new_flags[`FLG_NEG] = result[`WORD_W - 1];
    new_flags[`FLG_CARRY] = 1'b0;
    new_flags[`FLG_OVF] = 1'b0;
    new_flags[`FLG_PAR] = par_issue;
  end
endmodule
`default_nettype wire

/* File: issue_model.sv */
`timescale 1ns/1ns
`default_nettype none
`include "bfe_regs.svh"
module issue_model
(
  // Register port of the unit
  input wire logic ref_clk,
  output logic [7:0] addr,
  output logic [31:0] wdata,
  output logic wr_en,
  output logic rd_en,
  input wire logic [31:0] rdata
);
  initial
  begin
    addr = 8'h00;
    wdata = 32'h0000_0000;
    wr_en = 1'b0;
    rd_en = 1'b0;
  end
  // Released lines show the inverse so a stale value is never mistaken.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge ref_clk);
    wr_en <= 1'b0;
    addr <= ~a;
    wdata <= ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge ref_clk);
    rd_en <= 1'b0;
    addr <= ~a;
    #1;
    d = rdata;
  endtask
  task automatic issue(input logic [7:0] op, input logic [2:0] dst,
    input logic [2:0] src, input logic [2:0] pat, input logic sg,
    input logic par);
    wr(`REG_CMD, {op, 8'h00, par, 2'b00, sg, 1'b0, pat, 1'b0, src,
      1'b0, dst});
  endtask
endmodule
`default_nettype wire
